// >>> common/upc_pkg.sv
// Purpose: Shared constants and carrier types for the up/down event counter.
// Assumes: 200 MHz system clock and a fixed logic execution cycle.
// Notes:   Offsets are byte addresses on the AXI4-Lite register port.
package upc_pkg;

    localparam int unsigned CNT_W    = 16;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned ADDR_W   = 4;
    localparam int unsigned STRB_W   = DATA_W / 8;
    localparam int unsigned DIV_W    = 20;
    localparam int unsigned WIDTH_W  = 14;

    // Time base: clock period, logic execution cycle and pulse limits.
    localparam int unsigned CLK_PERIOD_NS      = 5;
    localparam int unsigned NS_PER_MS          = 1000000;
    localparam int unsigned LOGIC_CYCLE_MS     = 4;
    localparam int unsigned CYCLE_CLKS_DEF     = LOGIC_CYCLE_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned MIN_PULSE_SHORT_MS = 100;
    localparam int unsigned MIN_PULSE_LONG_MS  = 350;
    localparam int unsigned MAX_PULSE_MS       = 30000;

    // Least times round up, the longest time rounds down.
    localparam int unsigned MIN_SHORT_TICKS = (MIN_PULSE_SHORT_MS + LOGIC_CYCLE_MS - 1)
                                              / LOGIC_CYCLE_MS;
    localparam int unsigned MIN_LONG_TICKS  = (MIN_PULSE_LONG_MS + LOGIC_CYCLE_MS - 1)
                                              / LOGIC_CYCLE_MS;
    localparam int unsigned MAX_TICKS       = MAX_PULSE_MS / LOGIC_CYCLE_MS;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_UPPER  = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_START  = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hC;
    localparam logic [ADDR_W-1:0] WORD_MASK  = 4'hC;

    // Reset values.
    localparam logic [CNT_W-1:0] UPPER_RST = 16'hFFFF;
    localparam logic [CNT_W-1:0] START_RST = 16'h0001;

    // Field positions in the status word.
    localparam int unsigned STAT_FLAG_UP_BIT = 16;
    localparam int unsigned STAT_FLAG_LO_BIT = 17;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control word; bit 0 is auto_up.
    typedef struct packed {
        logic load_long;
        logic clear_long;
        logic auto_lo;
        logic auto_up;
    } upc_cfg_t;

    localparam int unsigned CFG_W = $bits(upc_cfg_t);

    // Event and control inputs, bit 0 is up.
    typedef struct packed {
        logic load;
        logic clear;
        logic down;
        logic up;
    } upc_pins_t;

endpackage

// >>> src/upc_pulse_qual.sv
// Purpose: Qualifies a low-high-low control pulse by its high time in logic cycles.
// Assumes: i_level is already synchronised; i_tick marks one logic execution cycle.
// Notes:   o_accept is a one-clock pulse on the tick that samples the falling edge.
`timescale 1ns/100ps
`default_nettype none
module upc_pulse_qual (
    input  wire logic I_CLK,
    input  wire logic I_RESET_N,
    input  wire logic i_tick,
    input  wire logic i_level,
    input  wire logic i_long,
    output var  logic o_accept
);

    typedef struct packed {
        logic                             prev;
        logic [upc_pkg::WIDTH_W-1:0]      width;
    } upc_qual_st_t;

    localparam logic [upc_pkg::WIDTH_W-1:0] MIN_S = upc_pkg::WIDTH_W'(upc_pkg::MIN_SHORT_TICKS);
    localparam logic [upc_pkg::WIDTH_W-1:0] MIN_L = upc_pkg::WIDTH_W'(upc_pkg::MIN_LONG_TICKS);
    localparam logic [upc_pkg::WIDTH_W-1:0] MAX_T = upc_pkg::WIDTH_W'(upc_pkg::MAX_TICKS);

    upc_qual_st_t s;
    upc_qual_st_t next_s;
    logic [upc_pkg::WIDTH_W-1:0] min_t;

    assign min_t = i_long ? MIN_L : MIN_S;

    // The width saturates one past the limit so an overlong pulse stays rejected.
    always_comb begin
        next_s   = s;
        o_accept = 1'b0;
        if (i_tick) begin
            next_s.prev = i_level;
            if (i_level) begin
                if (s.width <= MAX_T) begin
                    next_s.width = s.width + 1'b1;
                end
            end else begin
                next_s.width = '0;
                o_accept = s.prev && (s.width >= min_t) && (s.width <= MAX_T);
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    a_pulse_window: assert property (
        o_accept |-> (s.width >= MIN_S) && (s.width <= MAX_T) && !i_level && s.prev)
        else $error("Control pulse accepted outside its width window.");

endmodule
`default_nettype wire

// >>> src/upc_counter_top.sv
// Purpose: Up/down event counter with upper and lower threshold flags.
// Assumes: Event pins are asynchronous; registers are reached over AXI4-Lite.
// Notes:   Everything counting advances on one logic execution tick from a divider.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Automatic top mode: flag high one logic cycle at threshold, then count clears.
// - Manual top mode: flag holds at threshold, up edges ignored until count changes.
// - Automatic bottom mode: flag high one logic cycle at zero, then start value loads.
// - Manual bottom mode: flag holds at zero, down edges ignored until count changes.
// - Clear and load take precedence; count edges then have no effect.
// - Up edge adds one, down edge subtracts one, both together keep the count and clear both flags.
// - Clear gives zero, load gives start value, clear wins, both flags low.
// - Count is unsigned 16 bits, zero to 65535, readable as-is.
// - Clear or load pulse counts only with high time within minimum and 30 s.
module upc_counter_top #(
    parameter int unsigned CYCLE_CLKS = upc_pkg::CYCLE_CLKS_DEF
) (
    input  wire logic                       I_CLK,
    input  wire logic                       I_RESET_N,
    input  wire logic                       I_UP,
    input  wire logic                       I_DOWN,
    input  wire logic                       I_CLEAR,
    input  wire logic                       I_LOAD,
    output var  logic [upc_pkg::CNT_W-1:0]  O_COUNT,
    output var  logic                       O_UPPER_FLAG,
    output var  logic                       O_LOWER_FLAG,
    input  wire logic                       I_AXI_AWVALID,
    output var  logic                       O_AXI_AWREADY,
    input  wire logic [upc_pkg::ADDR_W-1:0] I_AXI_AWADDR,
    input  wire logic                       I_AXI_WVALID,
    output var  logic                       O_AXI_WREADY,
    input  wire logic [upc_pkg::DATA_W-1:0] I_AXI_WDATA,
    input  wire logic [upc_pkg::STRB_W-1:0] I_AXI_WSTRB,
    output var  logic                       O_AXI_BVALID,
    input  wire logic                       I_AXI_BREADY,
    output var  logic [1:0]                 O_AXI_BRESP,
    input  wire logic                       I_AXI_ARVALID,
    output var  logic                       O_AXI_ARREADY,
    input  wire logic [upc_pkg::ADDR_W-1:0] I_AXI_ARADDR,
    output var  logic                       O_AXI_RVALID,
    input  wire logic                       I_AXI_RREADY,
    output var  logic [upc_pkg::DATA_W-1:0] O_AXI_RDATA,
    output var  logic [1:0]                 O_AXI_RRESP
);

    localparam int unsigned CW = upc_pkg::CNT_W;
    localparam int unsigned DW = upc_pkg::DATA_W;
    localparam int unsigned AW = upc_pkg::ADDR_W;
    localparam logic [upc_pkg::DIV_W-1:0] DIV_LAST = upc_pkg::DIV_W'(CYCLE_CLKS - 1);

    typedef struct packed {
        logic [upc_pkg::DIV_W-1:0] div;
        logic                      tick;
        upc_pkg::upc_pins_t        s1;
        upc_pkg::upc_pins_t        s2;
        upc_pkg::upc_pins_t        s3;
        upc_pkg::upc_pins_t        filt;
        upc_pkg::upc_pins_t        prev;
        upc_pkg::upc_cfg_t         cfg;
        logic [CW-1:0]             upper;
        logic [CW-1:0]             start;
        logic [CW-1:0]             count;
        logic                      flag_up;
        logic                      flag_lo;
        logic                      aw_held;
        logic [AW-1:0]             aw_addr;
        logic                      w_held;
        logic [DW-1:0]             w_data;
        logic [upc_pkg::STRB_W-1:0] w_strb;
        logic                      awready;
        logic                      wready;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [DW-1:0]             rdata;
        logic [1:0]                rresp;
    } upc_state_t;

    upc_state_t s;
    upc_state_t next_s;
    logic       clr_acc;
    logic       ld_acc;
    logic       up_edge;
    logic       dn_edge;
    logic       no_ctl;

    function automatic logic is_mapped(input logic [AW-1:0] a);
        logic [AW-1:0] w;
        w = a & upc_pkg::WORD_MASK;
        return (w == upc_pkg::OFF_CTRL) || (w == upc_pkg::OFF_UPPER) ||
               (w == upc_pkg::OFF_START) || (w == upc_pkg::OFF_STATUS);
    endfunction

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                            input logic [DW-1:0] d,
                                            input logic [upc_pkg::STRB_W-1:0] st);
        logic [DW-1:0] res;
        res = old;
        for (int b = 0; b < upc_pkg::STRB_W; b++) begin
            if (st[b]) begin
                res[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return res;
    endfunction

    upc_pulse_qual u_clear_qual (
        .I_CLK     (I_CLK),
        .I_RESET_N (I_RESET_N),
        .i_tick    (s.tick),
        .i_level   (s.filt.clear),
        .i_long    (s.cfg.clear_long),
        .o_accept  (clr_acc)
    );

    upc_pulse_qual u_load_qual (
        .I_CLK     (I_CLK),
        .I_RESET_N (I_RESET_N),
        .i_tick    (s.tick),
        .i_level   (s.filt.load),
        .i_long    (s.cfg.load_long),
        .o_accept  (ld_acc)
    );

    assign up_edge = s.filt.up && !s.prev.up;
    assign dn_edge = s.filt.down && !s.prev.down;
    assign no_ctl  = !clr_acc && !ld_acc;

    always_comb begin
        logic [DW-1:0] wr_word;
        logic [AW-1:0] wa;
        logic [AW-1:0] ra;
        wr_word = '0;
        wa      = s.aw_addr & upc_pkg::WORD_MASK;
        ra      = I_AXI_ARADDR & upc_pkg::WORD_MASK;
        next_s  = s;

        // Logic execution tick from the clock divider.
        if (s.div == DIV_LAST) begin
            next_s.div  = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.div  = s.div + 1'b1;
            next_s.tick = 1'b0;
        end

        // A pin level changes only once the second and third stages agree.
        next_s.s1   = upc_pkg::upc_pins_t'({I_LOAD, I_CLEAR, I_DOWN, I_UP});
        next_s.s2   = s.s1;
        next_s.s3   = s.s2;
        next_s.filt = (s.s2 & s.s3) | (s.filt & (s.s2 | s.s3));

        if (s.tick) begin
            next_s.prev = s.filt;
            if (clr_acc) begin
                next_s.count   = '0;
                next_s.flag_up = 1'b0;
                next_s.flag_lo = 1'b0;
            end else if (ld_acc) begin
                next_s.count   = s.start;
                next_s.flag_up = 1'b0;
                next_s.flag_lo = 1'b0;
            end else if (s.cfg.auto_up && s.flag_up) begin
                next_s.count   = '0;
                next_s.flag_up = 1'b0;
                next_s.flag_lo = 1'b0;
            end else if (s.cfg.auto_lo && s.flag_lo) begin
                next_s.count   = s.start;
                next_s.flag_up = 1'b0;
                next_s.flag_lo = 1'b0;
            end else if (up_edge && dn_edge) begin
                next_s.flag_up = 1'b0;
                next_s.flag_lo = 1'b0;
            end else if (up_edge) begin
                // A count at or above the threshold never wraps past 16 bits.
                if (s.count >= s.upper) begin
                    next_s.flag_up = 1'b1;
                end else begin
                    next_s.count   = s.count + 1'b1;
                    next_s.flag_up = ((s.count + 1'b1) == s.upper);
                end
                next_s.flag_lo = 1'b0;
            end else if (dn_edge) begin
                if (s.count == '0) begin
                    next_s.flag_lo = 1'b1;
                end else begin
                    next_s.count   = s.count - 1'b1;
                    next_s.flag_lo = (s.count == CW'(1));
                end
                next_s.flag_up = 1'b0;
            end
        end

        // Write address and data are taken in either order.
        if (I_AXI_AWVALID && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = I_AXI_AWADDR;
        end
        if (I_AXI_WVALID && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.w_data = I_AXI_WDATA;
            next_s.w_strb = I_AXI_WSTRB;
        end
        if (s.bvalid && I_AXI_BREADY) begin
            next_s.bvalid = 1'b0;
        end
        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = is_mapped(s.aw_addr) ? upc_pkg::RESP_OKAY : upc_pkg::RESP_SLVERR;
            case (wa)
                upc_pkg::OFF_CTRL: begin
                    wr_word    = merge(DW'(s.cfg), s.w_data, s.w_strb);
                    next_s.cfg = upc_pkg::upc_cfg_t'(wr_word[upc_pkg::CFG_W-1:0]);
                end
                upc_pkg::OFF_UPPER: begin
                    wr_word      = merge(DW'(s.upper), s.w_data, s.w_strb);
                    next_s.upper = wr_word[CW-1:0];
                end
                upc_pkg::OFF_START: begin
                    wr_word      = merge(DW'(s.start), s.w_data, s.w_strb);
                    next_s.start = wr_word[CW-1:0];
                end
                default: begin
                    wr_word = '0;
                end
            endcase
        end
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready  = !next_s.w_held && !next_s.bvalid;

        if (s.rvalid && I_AXI_RREADY) begin
            next_s.rvalid = 1'b0;
        end
        if (I_AXI_ARVALID && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = is_mapped(I_AXI_ARADDR) ? upc_pkg::RESP_OKAY : upc_pkg::RESP_SLVERR;
            case (ra)
                upc_pkg::OFF_CTRL:   next_s.rdata = DW'(s.cfg);
                upc_pkg::OFF_UPPER:  next_s.rdata = DW'(s.upper);
                upc_pkg::OFF_START:  next_s.rdata = DW'(s.start);
                upc_pkg::OFF_STATUS: begin
                    next_s.rdata = DW'(s.count);
                    next_s.rdata[upc_pkg::STAT_FLAG_UP_BIT] = s.flag_up;
                    next_s.rdata[upc_pkg::STAT_FLAG_LO_BIT] = s.flag_lo;
                end
                default:             next_s.rdata = '0;
            endcase
        end
        next_s.arready = !next_s.rvalid;
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s         <= '0;
            s.upper   <= upc_pkg::UPPER_RST;
            s.start   <= upc_pkg::START_RST;
            s.awready <= 1'b1;
            s.wready  <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign O_COUNT       = s.count;
    assign O_UPPER_FLAG  = s.flag_up;
    assign O_LOWER_FLAG  = s.flag_lo;
    assign O_AXI_AWREADY = s.awready;
    assign O_AXI_WREADY  = s.wready;
    assign O_AXI_BVALID  = s.bvalid;
    assign O_AXI_BRESP   = s.bresp;
    assign O_AXI_ARREADY = s.arready;
    assign O_AXI_RVALID  = s.rvalid;
    assign O_AXI_RDATA   = s.rdata;
    assign O_AXI_RRESP   = s.rresp;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    a_clear_wins: assert property (
        s.tick && clr_acc |=> (s.count == '0) && !s.flag_up && !s.flag_lo)
        else $error("Accepted clear did not zero the count and flags.");
    a_load_start: assert property (
        s.tick && ld_acc && !clr_acc |=> (s.count == $past(s.start)) && !s.flag_up && !s.flag_lo)
        else $error("Accepted load did not set the start value.");
    a_up_increment: assert property (
        s.tick && no_ctl && up_edge && !dn_edge && !s.flag_up && !s.flag_lo &&
        (s.count < s.upper) |=> s.count == $past(s.count) + 1'b1)
        else $error("Up edge did not add one.");
    a_both_edges_hold: assert property (
        s.tick && no_ctl && up_edge && dn_edge && !s.flag_up && !s.flag_lo
        |=> $stable(s.count) && !s.flag_up && !s.flag_lo)
        else $error("Simultaneous edges changed the count.");
    a_auto_wrap_zero: assert property (
        s.tick && no_ctl && s.cfg.auto_up && s.flag_up |=> (s.count == '0) && !s.flag_up)
        else $error("Automatic top mode did not clear after one cycle.");
    a_auto_reload_start: assert property (
        s.tick && no_ctl && s.cfg.auto_lo && s.flag_lo && !(s.cfg.auto_up && s.flag_up)
        |=> (s.count == $past(s.start)) && !s.flag_lo)
        else $error("Automatic bottom mode did not reload the start value.");
    a_manual_top_hold: assert property (
        s.tick && no_ctl && !s.cfg.auto_up && s.flag_up && up_edge && !dn_edge
        |=> s.flag_up && $stable(s.count))
        else $error("Manual top mode did not ignore the up edge.");
    a_manual_bottom_hold: assert property (
        s.tick && no_ctl && !s.cfg.auto_lo && s.flag_lo && dn_edge && !up_edge &&
        !(s.cfg.auto_up && s.flag_up) |=> s.flag_lo && (s.count == '0))
        else $error("Manual bottom mode did not ignore the down edge.");
    a_count_on_tick: assert property (
        !s.tick |=> $stable(s.count) && $stable(s.flag_up) && $stable(s.flag_lo))
        else $error("Count moved outside a logic tick.");

    c_auto_wrap:   cover property (s.tick && s.cfg.auto_up && s.flag_up ##1 s.count == '0);
    c_clear_taken: cover property (s.tick && clr_acc);
    c_manual_hold: cover property (s.tick && !s.cfg.auto_lo && s.flag_lo && dn_edge);
    c_reg_read:    cover property (s.rvalid && I_AXI_RREADY);

endmodule
`default_nettype wire

// >>> testbench/upc_safety_src.sv
// Purpose: Drives the count and control pins as the surrounding safety logic.
// Assumes: Every level is held at least one logic tick plus the synchroniser delay.
// Notes:   The bench picks the pulse widths, including widths that must be ignored.
`timescale 1ns/100ps
`default_nettype none
module upc_safety_src (
    input  wire logic               I_CLK,
    output var  upc_pkg::upc_pins_t o_pins
);
    initial o_pins = 4'h0;
    // The level is applied after an edge and lasts n clocks.
    task automatic hold(input upc_pkg::upc_pins_t p, input int n);
        @(posedge I_CLK);
        o_pins <= p;
        repeat (n - 1) @(posedge I_CLK);
    endtask
endmodule
`default_nettype wire

// >>> testbench/up_down_event_counter_bench.sv
// Purpose: Self-checking bench comparing the counter with a behavioural model.
// Assumes: The logic tick is shortened to four clocks.
// Notes:   Registers are reached over AXI4-Lite; one write checks a partial byte strobe.
`timescale 1ns/100ps
`default_nettype none
module up_down_event_counter_bench;
    localparam int CYC = 4;
    localparam logic [3:0] PP [11] = '{4'h8, 4'h4, 4'hC, 4'h8, 4'h4, 4'h4, 4'h8, 4'h8, 4'h8,
                                       4'h8, 4'h4};
    localparam int PT [11] = '{30, 10, 30, 30, 50, 100, 7600, 24, 50, 88, 25};
    localparam int PC [11] = '{0, 0, 0, 0, 4, 4, 0, 0, 8, 8, 0};
    logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0;
    logic        arv = 1'b0, rre = 1'b0, awr, wrd, bv, arr, rv, fu, fl;
    logic [3:0]  awa = 4'h0, ara = 4'h0, ws = 4'hF;
    logic [31:0] wd = 32'h0, rdat, seed = 32'h7219;
    logic [15:0] cnt;
    logic [1:0]  bresp, rresp;
    int          failures = 0, samples_checked = 0, uh = 0, lh = 0;
    int          m_cnt = 0, m_fu = 0, m_fl = 0, upper = 3, start = 2;
    upc_pkg::upc_pins_t pins, pv;

    upc_safety_src src (.I_CLK(clk), .o_pins(pins));
    upc_counter_top #(.CYCLE_CLKS(CYC)) uut (
        .I_CLK(clk), .I_RESET_N(rst_n), .I_UP(pins.up), .I_DOWN(pins.down),
        .I_CLEAR(pins.clear), .I_LOAD(pins.load), .O_COUNT(cnt), .O_UPPER_FLAG(fu),
        .O_LOWER_FLAG(fl), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_AWADDR(awa),
        .I_AXI_WVALID(wv), .O_AXI_WREADY(wrd), .I_AXI_WDATA(wd), .I_AXI_WSTRB(ws),
        .O_AXI_BVALID(bv), .I_AXI_BREADY(bre), .O_AXI_BRESP(bresp), .I_AXI_ARVALID(arv),
        .O_AXI_ARREADY(arr), .I_AXI_ARADDR(ara), .O_AXI_RVALID(rv), .I_AXI_RREADY(rre),
        .O_AXI_RDATA(rdat), .O_AXI_RRESP(rresp));

    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        uh += fu;
        lh += fl;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] m_st();
        return {14'h0, m_fl[0], m_fu[0], m_cnt[15:0]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bit ad, dd;
        ad = 0;
        dd = 0;
        @(posedge clk);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; bre <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awr === 1'b1) begin ad = 1; awv <= 1'b0; end
            if (wrd === 1'b1) begin dd = 1; wv <= 1'b0; end
        end
        do @(posedge clk); while (bv !== 1'b1);
        bre <= 1'b0;
        chk({30'h0, bresp}, {30'h0, upc_pkg::RESP_OKAY});
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        arv <= 1'b1; ara <= a; rre <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rre <= 1'b0;
        chk(rdat, e);
        chk({30'h0, rresp}, {30'h0, upc_pkg::RESP_OKAY});
    endtask
    // One count event; the level pair spans enough ticks to be seen.
    task automatic ev(input upc_pkg::upc_pins_t p);
        src.hold(p, 3 * CYC);
        src.hold(4'h0, 3 * CYC);
        if (p.up && p.down) begin m_fu = 0; m_fl = 0; end
        else if (p.up) begin
            if (m_cnt < upper) m_cnt++;
            m_fu = (m_cnt == upper);
            m_fl = 0;
        end else begin
            if (m_cnt > 0) m_cnt--;
            m_fl = (m_cnt == 0);
            m_fu = 0;
        end
        chk({14'h0, fl, fu, cnt}, m_st());
    endtask
    task automatic pulse(input upc_pkg::upc_pins_t p, input int ticks, input int ctl);
        int mn;
        mn = (p.clear ? ctl[2] : ctl[3]) ? upc_pkg::MIN_LONG_TICKS : upc_pkg::MIN_SHORT_TICKS;
        src.hold(p, ticks * CYC);
        src.hold(4'h0, 4 * CYC);
        if (ticks >= mn && ticks <= upc_pkg::MAX_TICKS) begin
            m_cnt = p.clear ? 0 : start;
            m_fu = 0;
            m_fl = 0;
        end
        chk({14'h0, fl, fu, cnt}, m_st());
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(upc_pkg::OFF_CTRL, 32'h0);
        rd_chk(upc_pkg::OFF_UPPER, {16'h0, upc_pkg::UPPER_RST});
        rd_chk(upc_pkg::OFF_START, {16'h0, upc_pkg::START_RST});
        wr(upc_pkg::OFF_UPPER, 32'h3);
        wr(upc_pkg::OFF_START, 32'h2);
        wr(upc_pkg::OFF_STATUS, 32'hFFFF);
        ws <= 4'h2;
        wr(upc_pkg::OFF_UPPER, 32'h0000AB00);
        rd_chk(upc_pkg::OFF_UPPER, 32'h0000AB03);
        ws <= 4'hF;
        wr(upc_pkg::OFF_UPPER, 32'h3);
        rd_chk(upc_pkg::OFF_UPPER, 32'h3);
        rd_chk(upc_pkg::OFF_STATUS, m_st());
        $display("test registers done");
        repeat (4) ev(4'h1);
        repeat (4) ev(4'h2);
        ev(4'h3);
        ev(4'h1);
        rd_chk(upc_pkg::OFF_STATUS, m_st());
        $display("test manual limits done");
        for (int i = 0; i < 11; i++) begin
            wr(upc_pkg::OFF_CTRL, PC[i]);
            pulse(PP[i], PT[i], PC[i]);
        end
        $display("test pulses done");
        pulse(4'h8, 30, 0);
        src.hold(4'h4, 30 * CYC);
        src.hold(4'h1, 3 * CYC);
        src.hold(4'h0, 3 * CYC);
        m_cnt = 0;
        chk({14'h0, fl, fu, cnt}, m_st());
        $display("test precedence done");
        wr(upc_pkg::OFF_CTRL, 32'h1);
        repeat (2) ev(4'h1);
        uh = 0;
        src.hold(4'h1, 3 * CYC);
        src.hold(4'h0, 6 * CYC);
        chk(uh, CYC);
        chk({fu, cnt}, 17'h0);
        lh = 0;
        wr(upc_pkg::OFF_CTRL, 32'h2);
        // The count is already zero; a down edge raises the lower flag, which the reload action then follows.
        src.hold(4'h2, 3 * CYC);
        src.hold(4'h0, 6 * CYC);
        chk(lh, CYC);
        chk(cnt, start);
        m_cnt = start;
        wr(upc_pkg::OFF_CTRL, 32'h0);
        $display("test auto modes done");
        upper = 16'hFFFF;
        start = 16'hFFFF;
        wr(upc_pkg::OFF_UPPER, upper);
        wr(upc_pkg::OFF_START, start);
        pulse(4'h8, 30, 0);
        ev(4'h1);
        rd_chk(upc_pkg::OFF_STATUS, m_st());
        ev(4'h2);
        upper = 2 + xs() % 5;
        start = 1 + xs() % upper;
        wr(upc_pkg::OFF_UPPER, upper);
        wr(upc_pkg::OFF_START, start);
        pulse(4'h8, 30, 0);
        repeat (16) begin
            pv = 4'(1 + xs() % 3);
            ev(pv);
        end
        $display("test random walk done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
